// file: hdl/owc_warmup.sv
// Warm-up counter: two cascaded 8-bit counters as one 16-bit up-counter.
// Assumes software drives control bits on clk_in; count source ticks are pins.
`timescale 1ns/1ns
`include "owc_consts.svh"
module owc_warmup
   import owc_pkg::*;
(
   input  wire logic                    clk_in,
   input  wire logic                    arst_n_in,
   input  wire logic                    ce_in,
   input  wire logic                    upper_timer_start_bit_in,
   input  wire logic                    variant_to_fast_in,
   input  wire logic [`OWC_BYTE_W-1:0]  threshold_high_byte_in,
   input  wire logic [`OWC_BYTE_W-1:0]  threshold_low_byte_in,
   input  wire logic                    upper_timer_flipflop_initial_in,
   input  wire logic                    lower_timer_flipflop_initial_in,
   input  wire logic                    slow_tick_in,
   input  wire logic                    fast_tick_in,
   output logic                         upper_timer_interrupt_out,
   output logic [`OWC_CNT_W-1:0]        count_out,
   output logic                         running_out,
   output logic                         pulse_pins_out
);
   logic                    slow_rise;
   logic                    fast_rise;
   logic                    tick;
   logic [`OWC_BYTE_W-1:0]  low_q;
   logic [`OWC_BYTE_W-1:0]  high_q;
   logic                    hit;
   owc_state_t              state_q;

   // Upper byte of the threshold against the upper counter byte only
   function automatic logic upper_match(input logic [`OWC_BYTE_W-1:0] cnt_hi,
                                        input logic [`OWC_BYTE_W-1:0] thr_hi);
      upper_match = (cnt_hi == thr_hi);
   endfunction : upper_match

   owc_tick_sync u_slow (
      .clk_in    (clk_in),
      .arst_n_in (arst_n_in),
      .ce_in     (ce_in),
      .async_in  (slow_tick_in),
      .rise_out  (slow_rise)
   );
   owc_tick_sync u_fast (
      .clk_in    (clk_in),
      .arst_n_in (arst_n_in),
      .ce_in     (ce_in),
      .async_in  (fast_tick_in),
      .rise_out  (fast_rise)
   );

   // Source select by variant; tick period sets warm-up time
   assign tick = (variant_to_fast_in == OWC_VAR_TO_FAST) ? fast_rise : slow_rise;
   // Low threshold byte deliberately unused; lower counter byte still counts
   assign hit = upper_match(high_q, threshold_high_byte_in) && (low_q == 8'h00)
                && (high_q != 8'h00);

   // Run/match sequencing; stop bit wins at once
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_q <= OWC_IDLE;
      end else if (ce_in) begin
         case (state_q)
            OWC_IDLE: begin
               if (upper_timer_start_bit_in) begin
                  state_q <= OWC_COUNT;
               end
            end
            OWC_COUNT: begin
               if (!upper_timer_start_bit_in) begin
                  state_q <= OWC_IDLE;
               end else if (hit) begin
                  state_q <= OWC_MATCH;
               end
            end
            OWC_MATCH: begin
               state_q <= upper_timer_start_bit_in ? OWC_COUNT : OWC_IDLE;
            end
            default: begin
               state_q <= OWC_IDLE;
            end
         endcase
      end
   end

   // Cascaded counters: carry from low byte into high byte
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         low_q  <= 8'h00;
         high_q <= 8'h00;
      end else if (ce_in) begin
         if (state_q == OWC_MATCH) begin
            low_q  <= 8'h00;
            high_q <= 8'h00;
         end else if (state_q == OWC_COUNT && upper_timer_start_bit_in && tick && !hit) begin
            low_q <= low_q + 8'h01;
            if (low_q == 8'hFF) begin
               high_q <= high_q + 8'h01;
            end
         end
      end
   end

   // One-cycle interrupt pulse on match, none once stopped
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         upper_timer_interrupt_out <= 1'b0;
      end else if (ce_in) begin
         upper_timer_interrupt_out <= (state_q == OWC_COUNT) && upper_timer_start_bit_in && hit;
      end
   end

   // Status outputs registered
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         count_out      <= `OWC_CNT_RST;
         running_out    <= 1'b0;
         pulse_pins_out <= 1'b0;
      end else if (ce_in) begin
         count_out   <= {high_q, low_q};
         running_out <= (state_q != OWC_IDLE);
         // Pins stay quiet only if software holds both initial bits low
         pulse_pins_out <= upper_timer_flipflop_initial_in | lower_timer_flipflop_initial_in;
      end
   end

   // Assertions
   sequence s_hit_counting;
      ce_in && state_q == OWC_COUNT && upper_timer_start_bit_in && hit;
   endsequence

   a_match_irq: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      s_hit_counting |=> upper_timer_interrupt_out)
      else $error("match did not raise interrupt");
   a_match_clear: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      s_hit_counting ##1 ce_in |=> (low_q == 8'h00 && high_q == 8'h00))
      else $error("counter not cleared after match");
   a_stop_quiet: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (ce_in && !upper_timer_start_bit_in) |=> !upper_timer_interrupt_out)
      else $error("interrupt while stopped");
   a_stop_freeze: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (ce_in && !upper_timer_start_bit_in && state_q != OWC_MATCH) |=> $stable({high_q, low_q}))
      else $error("counter moved while stopped");
   a_upper_only: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      upper_timer_interrupt_out |-> $past(high_q) == $past(threshold_high_byte_in))
      else $error("match ignored upper byte");
   a_count_step: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (ce_in && state_q == OWC_COUNT && upper_timer_start_bit_in && tick && !hit)
      |=> {high_q, low_q} == $past({high_q, low_q}) + 16'h0001)
      else $error("16-bit count step wrong");
   // A quiet selected pin leaves the counter alone, whatever the other pin does
   a_src_select: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (ce_in && state_q == OWC_COUNT && !hit && (variant_to_fast_in ? !fast_rise : !slow_rise))
      |=> $stable({high_q, low_q}))
      else $error("count source mismatch");
   a_irq_pulse: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (upper_timer_interrupt_out && ce_in) |=> !upper_timer_interrupt_out)
      else $error("interrupt longer than one cycle");

   // One accepted tick of the running counter
   sequence s_step_counting;
      ce_in && state_q == OWC_COUNT && upper_timer_start_bit_in && tick && !hit;
   endsequence

   // Low byte wrap must carry exactly one into the high byte
   a_carry_up: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (s_step_counting ##0 (low_q == 8'hFF)) |=> (low_q == 8'h00 && high_q == ($past(high_q) + 8'h01)))
      else $error("carry into high byte lost");

   // No wrap, so the high byte must hold
   a_no_carry: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (s_step_counting ##0 (low_q != 8'hFF)) |=> $stable(high_q))
      else $error("high byte moved without carry");

   // Upper byte equal while the lower byte is not yet zero is no match
   a_low_ignored: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (ce_in && high_q == threshold_high_byte_in && low_q != 8'h00) |=> !upper_timer_interrupt_out)
      else $error("match taken before lower byte cleared");

   // Start bit is taken on the next edge
   a_start_run: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (ce_in && state_q == OWC_IDLE && upper_timer_start_bit_in) |=> state_q == OWC_COUNT)
      else $error("start not taken");

   // After the clear the count resumes while start stays high
   a_match_resume: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (ce_in && state_q == OWC_MATCH && upper_timer_start_bit_in) |=> state_q == OWC_COUNT)
      else $error("count did not resume after match");

   // Stop drops to idle from counting and from the match step alike
   a_stop_idle: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (ce_in && !upper_timer_start_bit_in && state_q != OWC_IDLE) |=> state_q == OWC_IDLE)
      else $error("stop did not reach idle");

   // Running flag tracks the sequencer one edge late
   a_run_flag: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      ce_in |=> running_out == ($past(state_q) != OWC_IDLE))
      else $error("running flag wrong");

   // Visible count is the 16-bit pair one edge late
   a_count_out: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      ce_in |=> count_out == $past({high_q, low_q}))
      else $error("count output wrong");

   // Pulse pin warning follows either initial bit
   a_pins_follow: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      ce_in |=> pulse_pins_out == $past(upper_timer_flipflop_initial_in | lower_timer_flipflop_initial_in))
      else $error("pulse pin warning wrong");
endmodule : owc_warmup

// file: hdl/owc_consts.svh
// Constants for the oscillator warm-up counter.
// Assumes inclusion by bare name from files under hdl/.
`ifndef OWC_CONSTS_SVH
`define OWC_CONSTS_SVH
`define OWC_CNT_W        16
`define OWC_BYTE_W       8
`define OWC_CNT_RST      16'h0000
`define OWC_THR_MIN      16'h0100
`define OWC_THR_MAX      16'hFF00
`define OWC_CLK_NS       20
`define OWC_SYNC_STAGES  2
`endif

// file: hdl/owc_pkg.sv
// Types for the oscillator warm-up counter.
// Assumes owc_consts.svh sits beside it.
`include "owc_consts.svh"
package owc_pkg;
   typedef enum logic [1:0] {
      OWC_IDLE  = 2'b00,
      OWC_COUNT = 2'b01,
      OWC_MATCH = 2'b10
   } owc_state_t;
   typedef enum logic {
      OWC_VAR_TO_SLOW = 1'b0,
      OWC_VAR_TO_FAST = 1'b1
   } owc_variant_t;
endpackage : owc_pkg

// file: hdl/owc_tick_sync.sv
// Two-stage synchroniser plus rising-edge detect for the count source tick.
// Assumes the tick is a slow pin-level clock foreign to clk_in.
`timescale 1ns/1ns
module owc_tick_sync (
   input  wire logic clk_in,
   input  wire logic arst_n_in,
   input  wire logic ce_in,
   input  wire logic async_in,
   output logic      rise_out
);
   logic meta_q;
   logic sync_q;
   logic last_q;

   // Only sync_q reads meta_q
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
         rise_out <= 1'b0;
      end else if (ce_in) begin
         meta_q <= async_in;
         sync_q <= meta_q;
         last_q <= sync_q;
         rise_out <= sync_q & ~last_q;
      end
   end
endmodule : owc_tick_sync

// file: bench/tb_top.sv
// Bench for the warm-up counter: drives the tick pins and control bits, checks counts and interrupts.
// Assumes hdl/ is on the include path; the design carries its own assertions.
`timescale 1ns/1ns
`include "owc_consts.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
   $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
   import owc_pkg::*;
   logic                   clk_in    = 1'b0;
   logic                   arst_n_in = 1'b0;
   logic                   start     = 1'b0;
   logic                   ce        = 1'b1;
   logic                   var_fast  = 1'b0;
   logic                   slow_tick = 1'b0;
   logic                   fast_tick = 1'b0;
   logic                   ff_up     = 1'b0;
   logic                   ff_lo     = 1'b0;
   logic [`OWC_BYTE_W-1:0] thr_hi    = 8'h01;
   logic [`OWC_BYTE_W-1:0] thr_lo    = 8'h00;
   logic                   irq;
   logic                   run;
   logic                   pins;
   logic [`OWC_CNT_W-1:0]  cnt;
   int                     bad_count = 0;
   int                     n_compared = 0;
   int                     irq_n = 0;
   int                     cyc = 0;

   owc_warmup owc_warmup_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .ce_in(ce),
      .upper_timer_start_bit_in(start), .variant_to_fast_in(var_fast),
      .threshold_high_byte_in(thr_hi), .threshold_low_byte_in(thr_lo),
      .upper_timer_flipflop_initial_in(ff_up), .lower_timer_flipflop_initial_in(ff_lo),
      .slow_tick_in(slow_tick), .fast_tick_in(fast_tick), .upper_timer_interrupt_out(irq),
      .count_out(cnt), .running_out(run), .pulse_pins_out(pins));

   // 50 MHz clock
   always #10 clk_in = ~clk_in;

   // Interrupt cycles and hang guard; a stuck interrupt shows up as extra counts
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (irq === 1'b1) irq_n <= irq_n + 1;
      if (cyc == 15000) begin
         bad_count++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("Compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : tally_and_finish

   // Pin ticks of 9 cycles, well under clk/4, so each count lands before the next rise
   task automatic ticks(input int n, input logic fast);
      repeat (n) begin
         @(posedge clk_in);
         if (fast) fast_tick <= 1'b1; else slow_tick <= 1'b1;
         repeat (4) @(posedge clk_in);
         fast_tick <= 1'b0;
         slow_tick <= 1'b0;
         repeat (4) @(posedge clk_in);
      end
   endtask : ticks

   // Reset, set up a variant, count to just below the match, then across it
   task automatic warmup(input logic fast, input logic [7:0] th, input logic [7:0] lo);
      int base;
      @(posedge clk_in);
      arst_n_in <= 1'b0;
      repeat (16) @(posedge clk_in);
      arst_n_in <= 1'b1;
      var_fast  <= fast;
      thr_hi    <= th;
      thr_lo    <= lo;
      @(posedge clk_in);
      start <= 1'b1;
      repeat (3) @(posedge clk_in);
      `CHK("running", 1'b1, run)
      ticks(3, !fast);
      `CHK("other pin ignored", 16'h0000, cnt)
      base = irq_n;
      ticks(int'(th) * 256 - 1, fast);
      `CHK("count below match", 16'(int'(th) * 256 - 1), cnt)
      `CHK("no early irq", base, irq_n)
      ticks(1, fast);
      `CHK("one irq pulse", base + 1, irq_n)
      `CHK("cleared on match", 16'h0000, cnt)
      ticks(3, fast);
      `CHK("resumes", 16'h0003, cnt)
      // Enable low freezes counter and synchronisers alike
      ce <= 1'b0;
      ticks(2, fast);
      `CHK("frozen by enable", 16'h0003, cnt)
      ce <= 1'b1;
      start <= 1'b0;
      ticks(4, fast);
      `CHK("halted count", 16'h0003, cnt)
      `CHK("idle", 1'b0, run)
      `CHK("no irq halted", base + 1, irq_n)
      $display("Test warmup fast=%0d th=%0h done", fast, th);
   endtask : warmup

   initial begin
      // Low byte nonzero must not shift the match point
      warmup(1'b0, 8'h01, 8'hFF);
      warmup(1'b1, 8'h02, 8'h80);
      // Pulse pins follow the initial bits
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_in);
         {ff_up, ff_lo} <= 2'(i);
         repeat (3) @(posedge clk_in);
         `CHK("pulse pins", (i != 0), pins)
      end
      $display("Test pulse pins done");
      tally_and_finish();
   end
endmodule : tb_top
